// >>> core/tdba_defines.svh
// Constants of the timer DMA burst access front end
// Operation
// RULE_01 - Burst length field value plus one gives transfers per DMA burst.
// RULE_02 - Burst base field picks the first register the window reaches.
// RULE_03 - Base counts register indices from timer control one upward.
// RULE_04 - Burst control and window registers exist only with built-in DMA.
// RULE_05 - Software writes reserved control bits as zero; they read zero.
// RULE_06 - Window access goes to base plus index; index wraps at length.
`ifndef TDBA_DEFINES_SVH
`define TDBA_DEFINES_SVH

// Wishbone byte offsets
`define TDBA_OFS_CTRL      8'h48
`define TDBA_OFS_WIN       8'h4C

// Burst control fields
`define TDBA_LEN_MSB       12
`define TDBA_LEN_LSB       8
`define TDBA_BASE_MSB      4
`define TDBA_BASE_LSB      0
`define TDBA_CTRL_MASK     16'h1F1F
`define TDBA_CTRL_RST      16'h0000
`define TDBA_WIN_RST       16'h0000

// Widths
`define TDBA_FIELD_W       5
`define TDBA_REG_W         16
`define TDBA_TGT_W         6

`endif

// >>> core/tdba_pkg.sv
// Types shared by the timer DMA burst access front end
package tdba_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_FWD  = 3'b010,
    ST_DONE = 3'b100
  } tdba_state_e;

  typedef logic [4:0] tdba_field_t;
  typedef logic [5:0] tdba_target_t;

endpackage

// >>> core/tdba_burst_seq.sv
// Transfer index counter and target register index of one burst
`timescale 1ns/1ps
`include "tdba_defines.svh"

module tdba_burst_seq
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic                clear_i,
  input  wire logic                step_i,
  input  wire tdba_pkg::tdba_field_t len_i,
  input  wire tdba_pkg::tdba_field_t base_i,
  output      tdba_pkg::tdba_field_t idx_o,
  output      logic                last_o,
  output      tdba_pkg::tdba_target_t target_o
);

  tdba_pkg::tdba_field_t idx_reg;
  tdba_pkg::tdba_field_t idx_next;
  logic                  last;

  // Length field value is the index of the final transfer
  assign last = (idx_reg >= len_i); // RULE_01

  always_comb
  begin
    idx_next = idx_reg;
    if (clear_i)
    begin
      idx_next = '0;
    end
    else if (step_i)
    begin
      // Wrap so the next burst starts again at the base register
      if (last)
      begin
        idx_next = '0; // RULE_06
      end
      else
      begin
        idx_next = idx_reg + 5'h01; // RULE_06
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idx_reg <= '0;
    end
    else if (ce_i)
    begin
      idx_reg <= idx_next;
    end
  end

  assign idx_o    = idx_reg;
  assign last_o   = last;
  // Base plus index, one bit wider so no sum is lost
  assign target_o = {1'b0, base_i} + {1'b0, idx_reg}; // RULE_02 RULE_03

endmodule

// >>> core/tdba_top.sv
// Timer DMA burst access front end with Wishbone slave
`timescale 1ns/1ps
`include "tdba_defines.svh"

module tdba_top
#(
  parameter int HAS_DMA = 1,
  parameter int ADR_W   = 8
)
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  // Wishbone classic slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [ADR_W-1:0]            wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output      logic [31:0]                 wb_dat_o,
  output      logic                        wb_ack_o,
  // DMA controller marks the start of a burst
  input  wire logic                        burst_start_i,
  // Timer register file port
  output      logic                        tmr_req_o,
  output      logic                        tmr_we_o,
  output      logic [`TDBA_TGT_W-1:0]      tmr_adr_o,
  output      logic [1:0]                  tmr_sel_o,
  output      logic [`TDBA_REG_W-1:0]      tmr_dat_o,
  input  wire logic [`TDBA_REG_W-1:0]      tmr_dat_i,
  input  wire logic                        tmr_ack_i,
  // Burst status
  output      logic [`TDBA_FIELD_W-1:0]    burst_idx_o,
  output      logic                        burst_last_o
);

  generate
    if (ADR_W < 7)
    begin : g_adr_chk
      $error("ADR_W too small to reach the burst registers");
    end
    if (HAS_DMA != 0 && HAS_DMA != 1)
    begin : g_dma_chk
      $error("HAS_DMA must be 0 or 1");
    end
    // Base plus index must never overflow the forwarded register index
    if (`TDBA_TGT_W != `TDBA_FIELD_W + 1)
    begin : g_tgt_chk
      $error("Target index must be one bit wider than the base field");
    end
  endgenerate

  localparam logic DMA_ON = (HAS_DMA != 0);

  // Word address match, byte lane bits ignored
  function automatic logic hit(input logic [ADR_W-1:0] adr,
                               input logic [7:0]       ofs);
    logic [ADR_W-1:0] full;
    full = ADR_W'(ofs);
    hit  = (adr[ADR_W-1:2] == full[ADR_W-1:2]);
  endfunction

  // Merge the two low byte lanes of a write into a 16-bit value
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
    begin
      res[7:0] = dat[7:0];
    end
    if (sel[1])
    begin
      res[15:8] = dat[15:8];
    end
    merge = res;
  endfunction

  tdba_pkg::tdba_state_e state_reg;
  logic [`TDBA_REG_W-1:0] ctrl_reg;
  logic [`TDBA_REG_W-1:0] ctrl_next;
  logic [`TDBA_REG_W-1:0] win_reg;
  logic [31:0]            dat_reg;
  logic                   ack_reg;
  logic                   req_reg;
  logic                   we_reg;
  logic [`TDBA_TGT_W-1:0] adr_reg;
  logic [1:0]             sel_reg;
  logic [`TDBA_REG_W-1:0] wdat_reg;

  logic                   new_req;
  logic                   ctrl_hit;
  logic                   win_hit;
  logic                   ctrl_wr;
  logic                   step;
  logic                   seq_clear;
  tdba_pkg::tdba_field_t  len_f;
  tdba_pkg::tdba_field_t  base_f;
  tdba_pkg::tdba_field_t  seq_idx;
  logic                   seq_last;
  tdba_pkg::tdba_target_t seq_target;

  // Ack drops in the cycle after it was given, so a held strobe
  // is never taken twice
  assign new_req  = wb_cyc_i && wb_stb_i && !ack_reg
                    && (state_reg == tdba_pkg::ST_IDLE);
  // Without the built-in DMA both offsets fall into unmapped space
  assign ctrl_hit = DMA_ON && hit(wb_adr_i, `TDBA_OFS_CTRL); // RULE_04
  assign win_hit  = DMA_ON && hit(wb_adr_i, `TDBA_OFS_WIN);  // RULE_04
  assign ctrl_wr  = new_req && ctrl_hit && wb_we_i;
  assign step     = (state_reg == tdba_pkg::ST_FWD) && tmr_ack_i;

  // A new control setting or a DMA burst start restarts the index
  assign seq_clear = ctrl_wr || burst_start_i;

  assign len_f  = ctrl_reg[`TDBA_LEN_MSB:`TDBA_LEN_LSB];   // RULE_01
  assign base_f = ctrl_reg[`TDBA_BASE_MSB:`TDBA_BASE_LSB]; // RULE_02

  // Reserved control bits are never stored, so they read as zero
  assign ctrl_next = merge(ctrl_reg, wb_dat_i, wb_sel_i)
                     & `TDBA_CTRL_MASK; // RULE_05

  tdba_burst_seq u_seq
  (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .clear_i  (seq_clear),
    .step_i   (step),
    .len_i    (len_f),
    .base_i   (base_f),
    .idx_o    (seq_idx),
    .last_o   (seq_last),
    .target_o (seq_target)
  );

  // Transfer state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= tdba_pkg::ST_IDLE;
    end
    else if (ce_i)
    begin
      unique case (state_reg)
        tdba_pkg::ST_IDLE:
        begin
          if (new_req && win_hit)
          begin
            state_reg <= tdba_pkg::ST_FWD;
          end
          else if (new_req)
          begin
            state_reg <= tdba_pkg::ST_DONE;
          end
        end
        tdba_pkg::ST_FWD:
        begin
          if (tmr_ack_i)
          begin
            state_reg <= tdba_pkg::ST_DONE;
          end
        end
        tdba_pkg::ST_DONE:
        begin
          state_reg <= tdba_pkg::ST_IDLE;
        end
        default:
        begin
          state_reg <= tdba_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Bus acknowledge: one cycle, in ST_DONE
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      ack_reg <= (state_reg == tdba_pkg::ST_IDLE && new_req && !win_hit)
                 || step;
    end
  end

  // Burst control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= `TDBA_CTRL_RST;
    end
    else if (ce_i && ctrl_wr)
    begin
      ctrl_reg <= ctrl_next; // RULE_01 RULE_02 RULE_05
    end
  end

  // Window register keeps the last value moved through it
  // Not readable on the bus: a window read always goes to the timer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      win_reg <= `TDBA_WIN_RST;
    end
    else if (ce_i && step)
    begin
      if (we_reg)
      begin
        win_reg <= wdat_reg;
      end
      else
      begin
        win_reg <= tmr_dat_i;
      end
    end
  end

  // Forwarded timer access, held until the timer acknowledges
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_reg  <= 1'b0;
      we_reg   <= 1'b0;
      adr_reg  <= '0;
      sel_reg  <= 2'h0;
      wdat_reg <= `TDBA_WIN_RST;
    end
    else if (ce_i)
    begin
      if (new_req && win_hit)
      begin
        req_reg  <= 1'b1;
        we_reg   <= wb_we_i;
        adr_reg  <= seq_target; // RULE_06 RULE_03
        sel_reg  <= wb_sel_i[1:0];
        wdat_reg <= wb_dat_i[15:0];
      end
      else if (step)
      begin
        req_reg <= 1'b0;
      end
    end
  end

  // Read data, upper half always zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_reg <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      dat_reg <= 32'h0000_0000;
      if (new_req && !wb_we_i && ctrl_hit)
      begin
        dat_reg <= {16'h0000, ctrl_reg};
      end
      else if (step && !we_reg)
      begin
        dat_reg <= {16'h0000, tmr_dat_i};
      end
      else if (step)
      begin
        dat_reg <= {16'h0000, wdat_reg};
      end
    end
  end

  // Burst status mirrors the sequencer after each update
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      burst_idx_o  <= '0;
      burst_last_o <= 1'b0;
    end
    else if (ce_i)
    begin
      burst_idx_o  <= seq_idx;
      burst_last_o <= seq_last;
    end
  end

  assign wb_ack_o  = ack_reg;
  assign wb_dat_o  = dat_reg;
  assign tmr_req_o = req_reg;
  assign tmr_we_o  = we_reg;
  assign tmr_adr_o = adr_reg;
  assign tmr_sel_o = sel_reg;
  assign tmr_dat_o = wdat_reg;

endmodule

// >>> bench/tdba_top_sva.sv
// Assertions on the burst access front end ports
`timescale 1ns/1ps
module tdba_top_sva
#(
  parameter int ADR_W = 8
)
(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             ce_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             burst_start_i,
  input wire logic             tmr_req_o,
  input wire logic             tmr_we_o,
  input wire logic [5:0]       tmr_adr_o,
  input wire logic [15:0]      tmr_dat_i,
  input wire logic             tmr_ack_i,
  input wire logic [4:0]       burst_idx_o,
  input wire logic             burst_last_o
);
  logic [4:0] len_q;
  logic [4:0] base_q;
  logic [4:0] idx_q;
  wire        is_ctl  = wb_adr_i[7:2] == 6'h12;
  wire        ctl_wr  = wb_ack_o && wb_we_i && is_ctl;
  wire        xfer    = tmr_req_o && tmr_ack_i && ce_i;
  // Shadow of the fields, updated one edge late where no transfer can run
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ctl_wr || (burst_start_i && ce_i))
      idx_q <= 5'h00;
    else if (xfer)
      idx_q <= (idx_q == len_q) ? 5'h00 : idx_q + 5'h01;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      {len_q, base_q} <= 10'h000;
    else if (ctl_wr)
    begin
      if (wb_sel_i[1])
        len_q <= wb_dat_i[12:8];
      if (wb_sel_i[0])
        base_q <= wb_dat_i[4:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_target_index: assert property (tmr_req_o |->
    tmr_adr_o == 6'(base_q) + 6'(idx_q))
    else $error("timer index is not base plus transfer index");
  a_ctrl_ack_next: assert property (wb_cyc_i && wb_stb_i && ce_i &&
    !wb_ack_o && !tmr_req_o && is_ctl |=> wb_ack_o)
    else $error("control access not answered next cycle");
  a_win_answer: assert property (xfer |=> wb_ack_o && !tmr_req_o)
    else $error("window not answered after timer answer");
  a_read_data: assert property (xfer && !tmr_we_o |=>
    wb_dat_o == {16'h0000, $past(tmr_dat_i)})
    else $error("window read data differs from timer data");
  a_req_holds: assert property (tmr_req_o && !tmr_ack_i && ce_i |=>
    tmr_req_o && $stable(tmr_adr_o) && $stable(tmr_we_o))
    else $error("timer request changed before its answer");
  a_ctrl_read: assert property (wb_ack_o && !wb_we_i && is_ctl |->
    wb_dat_o == {19'h00000, len_q, 3'h0, base_q})
    else $error("control read differs from stored fields");
  a_status_mirror: assert property (xfer ##1 (ce_i && !burst_start_i) |=>
    burst_idx_o == idx_q && burst_last_o == (idx_q >= len_q))
    else $error("burst status differs from transfer index");
endmodule

bind tdba_top tdba_top_sva #(.ADR_W(ADR_W)) u_sva (.clk_i(clk_i),
  .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .burst_start_i(burst_start_i),
  .tmr_req_o(tmr_req_o), .tmr_we_o(tmr_we_o), .tmr_adr_o(tmr_adr_o),
  .tmr_dat_i(tmr_dat_i), .tmr_ack_i(tmr_ack_i),
  .burst_idx_o(burst_idx_o), .burst_last_o(burst_last_o));

// >>> bench/tdba_timer_model.sv
// Behavioural timer register file behind the burst front end
`timescale 1ns/1ps
module tdba_timer_model
(
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [1:0]  sel_i,
  input  wire logic [15:0] dat_i,
  input  wire logic [3:0]  dly_i,
  output      logic [15:0] dat_o = 16'h0000,
  output      logic        ack_o = 1'b0
);
  logic [15:0] mem_reg [64];
  logic [3:0]  wait_reg = 4'h0;
  // Idle data flips every cycle so a late sample never matches
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    dat_o <= ~dat_o;
    if (req_i && !ack_o)
    begin
      wait_reg <= wait_reg + 4'h1;
      if (wait_reg >= dly_i)
      begin
        ack_o <= 1'b1;
        wait_reg <= 4'h0;
        dat_o <= mem_reg[adr_i];
        if (we_i && sel_i[0])
          mem_reg[adr_i][7:0] <= dat_i[7:0];
        if (we_i && sel_i[1])
          mem_reg[adr_i][15:8] <= dat_i[15:8];
      end
    end
  end
endmodule

// >>> bench/timer_dma_burst_access_bench.sv
// Self-checking bench of the burst access front end
`timescale 1ns/1ps
module timer_dma_burst_access_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        bst = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dw = 32'h0;
  logic [3:0]  sel = 4'h3;
  logic [3:0]  psel = 4'h3;
  logic [31:0] dr;
  logic        ack, req, twe, tack;
  logic [5:0]  tadr;
  logic [1:0]  tsel;
  logic [15:0] tdo, tdi;
  logic [3:0]  dly = 4'h0;
  logic [31:0] exp_q[$];
  logic [15:0] shd[64];
  logic [4:0]  lt[3] = '{5'h00, 5'h11, 5'h03};
  logic [4:0]  len, base, ix;
  int          err_count = 0;
  int          checks = 0;
  int          cyc_n = 0;
  always #50 clk_i = ~clk_i;
  tdba_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(stb),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .burst_start_i(bst),
    .tmr_req_o(req), .tmr_we_o(twe), .tmr_adr_o(tadr), .tmr_sel_o(tsel),
    .tmr_dat_o(tdo), .tmr_dat_i(tdi), .tmr_ack_i(tack), .burst_idx_o(),
    .burst_last_o());
  tdba_timer_model u_tmr (.clk_i(clk_i), .req_i(req), .we_i(twe),
    .adr_i(tadr), .sel_i(tsel), .dat_i(tdo), .dly_i(dly), .dat_o(tdi),
    .ack_o(tack));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [15:0] d, input logic [31:0] e);
    @(posedge clk_i);
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= {16'h0000, d};
    sel <= psel;
    dly <= 4'($urandom_range(0, 3));
    if (!w)
      exp_q.push_back(e);
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    stb <= 1'b0;
  endtask
  task automatic win(input logic w, input logic [15:0] d);
    logic [5:0] t;
    t = 6'(base) + 6'(ix);
    if (w)
      shd[t] = d;
    wb(w, 8'h4C, d, {16'h0000, shd[t]});
    ix = (ix == len) ? 5'h00 : ix + 5'h01;
  endtask
  task automatic ctl(input logic [4:0] l, input logic [4:0] b);
    wb(1'b1, 8'h48, {3'h0, l, 3'h0, b}, 32'h0);
    len = l;
    base = b;
    ix = 5'h00;
    wb(1'b0, 8'h48, 16'h0, {19'h0, l, 3'h0, b});
  endtask
  always @(posedge clk_i)
    if (ack === 1'b1 && !we)
      check(dr, exp_q.pop_front());
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n > 20000)
    begin
      err_count++;
      results();
    end
  end
  initial
  begin
    void'($urandom(49998));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h48, 16'h0, 32'h0);
    wb(1'b0, 8'h50, 16'h0, 32'h0);
    $display("test reset values done");
    for (int k = 0; k < 3; k++)
    begin
      ctl(lt[k], 5'(k));
      repeat (lt[k] + 1) win(1'b1, 16'($urandom));
      repeat (lt[k] + 2) win(1'b0, 16'h0);
      $display("test burst %0d done", k);
    end
    wb(1'b1, 8'h44, 16'hFFFF, 32'h0);
    wb(1'b0, 8'h48, 16'h0, {19'h0, len, 3'h0, base});
    $display("test unmapped write done");
    psel = 4'h2;
    wb(1'b1, 8'h48, 16'h061F, 32'h0);
    psel = 4'h3;
    len = 5'h06;
    ix = 5'h00;
    wb(1'b0, 8'h48, 16'h0, {19'h0, len, 3'h0, base});
    $display("test byte lane write done");
    win(1'b0, 16'h0);
    @(posedge clk_i);
    bst <= 1'b1;
    @(posedge clk_i);
    bst <= 1'b0;
    ix = 5'h00;
    win(1'b0, 16'h0);
    $display("test burst restart done");
    repeat (3) @(posedge clk_i);
    results();
  end
endmodule
